// File: logic/sysctl_pkg.sv
// Shared constants and carrier types for the system control register bank.
package sysctl_pkg;

  localparam logic [7:0]  ADDR_DEVICE_IDENTITY  = 8'h00;
  localparam logic [7:0]  ADDR_VENDOR_CODE      = 8'h04;
  localparam logic [7:0]  ADDR_PRODUCT_CODE     = 8'h06;
  localparam logic [7:0]  ADDR_PD_REVISION      = 8'h08;
  localparam logic [7:0]  ADDR_CONNECTOR_REV    = 8'h0A;
  localparam logic [7:0]  ADDR_WAKE_PROBE       = 8'h0E;
  localparam logic [7:0]  ADDR_TARGET_ADDRESS   = 8'h1A;
  // Registers of our own for the timer, pins and over-current event.
  localparam logic [7:0]  ADDR_TIMER_LO         = 8'h20;
  localparam logic [7:0]  ADDR_TIMER_HI         = 8'h21;
  localparam logic [7:0]  ADDR_TIMER_CTRL       = 8'h22;
  localparam logic [7:0]  ADDR_PIN_OUT_LO       = 8'h24;
  localparam logic [7:0]  ADDR_PIN_OUT_HI       = 8'h25;
  localparam logic [7:0]  ADDR_PIN_GUARD_LO     = 8'h26;
  localparam logic [7:0]  ADDR_PIN_GUARD_HI     = 8'h27;
  localparam logic [7:0]  ADDR_OC_STATUS        = 8'h28;

  localparam logic [15:0] RESET_PD_REVISION     = 16'h3010;
  localparam logic [15:0] RESET_CONNECTOR_REV   = 16'h0012;
  localparam logic [7:0]  WAKE_PROBE_VALUE      = 8'h02;
  localparam logic [15:0] RESET_PIN_OUT         = 16'h0000;
  localparam logic [15:0] RESET_PIN_GUARD       = 16'h0000;
  localparam logic [7:0]  READ_ZERO             = 8'h00;

  // Keep-alive oscillator rate; its edge is sampled in the main clock domain.
  localparam int          KEEPALIVE_HZ          = 20000;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       addrOvrEn;
    logic [6:0] ovrAddr;
    logic       pdRevValid;
    logic [15:0] pdRev;
    logic       connRevValid;
    logic [15:0] connRev;
  } otp_fields_t;

endpackage : sysctl_pkg

// File: logic/system_control_registers.sv
// System control register bank with one-shot timer, pin override and over-current events.
// Overview of operation
// R1: Sixteen-bit one-shot down counter stepped by the 20 kHz keep-alive tick.
// R2: On underflow raise the timer interrupt and halt; no automatic reload.
// R3: Up to ten general purpose pins are driven from host-programmed values.
// R4: Error conditions force guarded pins low in hardware without software help.
// R5: Either over-current comparator input sets a sticky, readable event.
// R6: Host must not write reserved addresses; such writes are simply dropped here.
// R7: Identity word gives device code high half and revision low half, read-only.
// R8: Wide registers sit little-endian, low byte at the base address.
// R9: Read-write vendor code at byte four, reset to a fixed code.
// R10: Read-write product code at byte six, reset to a fixed code.
// R11: Delivery revision loads from OTP at reset, else 3010h.
// R12: Connector revision loads from OTP at reset, else 12h.
// R13: Wake probe reads 02h when operational; host polls it after wake.
// R14: Target address bits 6:0 read-write; bit 7 reserved, reads zero.
// R15: Target address from strap at reset, or OTP override address if enabled.
// R16: Strap is sampled on every chip-level reset to set the target address.
// R17: While powered down the read data output is driven low.
// R18: Writes to read-only registers or bits are ignored.
`timescale 1ns/100ps
module system_control_registers
  import sysctl_pkg::*;
#(
  parameter int          PIN_COUNT   = 10,
  parameter logic [15:0] DEVICE_CODE = 16'h1234, // Arbitrary value.
  parameter logic [15:0] SILICON_REV = 16'h0001, // Arbitrary value.
  parameter logic [15:0] VENDOR_CODE = 16'hABCD, // Arbitrary value.
  parameter logic [15:0] PRODUCT_CODE = 16'h5678 // Arbitrary value.
)(
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  input  wire logic                 clkEn,
  input  wire reg_req_t             regReq,
  output logic [7:0]                regRdata,
  output logic                      regRvalid,
  input  wire otp_fields_t          otp,
  input  wire logic [6:0]           cfgStrapAddr,
  input  wire logic                 poweredDown,
  input  wire logic                 keepAliveClk,
  input  wire logic                 overcurrent_sense_input_a,
  input  wire logic                 overcurrent_sense_input_b,
  input  wire logic                 errorCondition,
  output logic [PIN_COUNT-1:0]      general_purpose_pin,
  output logic                      timerIrq,
  output logic [6:0]                targetAddress
);

  // The value and guard registers only promise ten usable pins.
  if (PIN_COUNT < 1 || PIN_COUNT > 10)
  begin : g_bad_pin_count
    $error("PIN_COUNT must lie between 1 and 10.");
  end

  logic [15:0] vendorQ, productQ, pdRevQ, connRevQ;
  logic [6:0]  targetQ;
  logic [15:0] timerCountQ;
  logic        timerRunQ, timerIrqQ;
  logic [15:0] pinOutQ, pinGuardQ;
  logic        ocFlagAQ, ocFlagBQ;
  logic [7:0]  regRdataQ;
  logic        regRvalidQ;
  logic [2:0]  kaSyncQ, ocaSyncQ, ocbSyncQ, errSyncQ;
  logic [1:0]  pdnSyncQ;
  logic        resetSeenQ;
  logic [6:0]  strapSyncQ [2];

  wire logic wrEn = clkEn && regReq.valid && regReq.write;
  wire logic rdEn = clkEn && regReq.valid && !regReq.write;

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] base);
    return a == base;
  endfunction : isAddr

  // Two-flop synchronisers; the third stage is only used for edge detection.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      kaSyncQ  <= 3'h0;
      ocaSyncQ <= 3'h0;
      ocbSyncQ <= 3'h0;
      errSyncQ <= 3'h0;
      pdnSyncQ <= 2'h3;
    end
    else if (clkEn)
    begin
      kaSyncQ  <= {kaSyncQ[1:0], keepAliveClk};
      ocaSyncQ <= {ocaSyncQ[1:0], overcurrent_sense_input_a};
      ocbSyncQ <= {ocbSyncQ[1:0], overcurrent_sense_input_b};
      errSyncQ <= {errSyncQ[1:0], errorCondition};
      pdnSyncQ <= {pdnSyncQ[0], poweredDown};
    end
  end

  wire logic kaTick   = kaSyncQ[1] && !kaSyncQ[2];
  wire logic ocaRise  = ocaSyncQ[1] && !ocaSyncQ[2];
  wire logic ocbRise  = ocbSyncQ[1] && !ocbSyncQ[2];
  wire logic errLevel = errSyncQ[1];
  wire logic pdnLevel = pdnSyncQ[1];

  // Strap is synchronised continuously and captured in the first cycle after reset.
  always_ff @(posedge ref_clk)
  begin
    if (clkEn)
    begin
      strapSyncQ[0] <= cfgStrapAddr;
      strapSyncQ[1] <= strapSyncQ[0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      resetSeenQ <= 1'b1;
    else if (clkEn)
      resetSeenQ <= 1'b0;
  end

  // Identity and revision registers, little-endian byte lanes.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      vendorQ  <= VENDOR_CODE;   // R9
      productQ <= PRODUCT_CODE;  // R10
      pdRevQ   <= 16'h0000;
      connRevQ <= 16'h0000;
    end
    else if (clkEn && resetSeenQ)
    begin
      pdRevQ   <= otp.pdRevValid ? otp.pdRev : RESET_PD_REVISION;      // R11
      connRevQ <= otp.connRevValid ? otp.connRev : RESET_CONNECTOR_REV; // R12
    end
    else if (wrEn)
    begin
      case (regReq.addr)
        ADDR_VENDOR_CODE:             vendorQ[7:0]   <= regReq.wdata; // R8
        ADDR_VENDOR_CODE + 8'h01:     vendorQ[15:8]  <= regReq.wdata; // R8
        ADDR_PRODUCT_CODE:            productQ[7:0]  <= regReq.wdata;
        ADDR_PRODUCT_CODE + 8'h01:    productQ[15:8] <= regReq.wdata;
        ADDR_PD_REVISION:             pdRevQ[7:0]    <= regReq.wdata;
        ADDR_PD_REVISION + 8'h01:     pdRevQ[15:8]   <= regReq.wdata;
        ADDR_CONNECTOR_REV:           connRevQ[7:0]  <= regReq.wdata;
        ADDR_CONNECTOR_REV + 8'h01:   connRevQ[15:8] <= regReq.wdata;
        default:                ;  // R6 R18
      endcase
    end
  end

  // Target address: strap or OTP override after every reset, then host writable.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      targetQ <= 7'h00;
    else if (clkEn && resetSeenQ)
      targetQ <= otp.addrOvrEn ? otp.ovrAddr : strapSyncQ[1]; // R15 R16
    else if (wrEn && isAddr(regReq.addr, ADDR_TARGET_ADDRESS))
      targetQ <= regReq.wdata[6:0]; // R14
  end

  // One-shot timer: a control write of bit 0 starts it, underflow halts it and raises the interrupt.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      timerCountQ <= 16'h0000;
      timerRunQ   <= 1'b0;
      timerIrqQ   <= 1'b0;
    end
    else if (clkEn)
    begin
      if (wrEn && isAddr(regReq.addr, ADDR_TIMER_LO))
        timerCountQ[7:0] <= regReq.wdata;
      else if (wrEn && isAddr(regReq.addr, ADDR_TIMER_HI))
        timerCountQ[15:8] <= regReq.wdata;
      else if (timerRunQ && kaTick)
        timerCountQ <= timerCountQ - 16'h0001; // R1
      if (timerRunQ && kaTick && timerCountQ == 16'h0000)
      begin
        timerRunQ <= 1'b0; // R2
        timerIrqQ <= 1'b1; // R2
      end
      else if (wrEn && isAddr(regReq.addr, ADDR_TIMER_CTRL))
      begin
        timerRunQ <= regReq.wdata[0];
        if (regReq.wdata[1])
          timerIrqQ <= 1'b0;
      end
    end
  end

  // Pin values and the guard mask that names pins forced low on error.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pinOutQ   <= RESET_PIN_OUT;
      pinGuardQ <= RESET_PIN_GUARD;
    end
    else if (wrEn)
    begin
      case (regReq.addr)
        ADDR_PIN_OUT_LO:   pinOutQ[7:0]    <= regReq.wdata; // R3
        ADDR_PIN_OUT_HI:   pinOutQ[15:8]   <= regReq.wdata;
        ADDR_PIN_GUARD_LO: pinGuardQ[7:0]  <= regReq.wdata;
        ADDR_PIN_GUARD_HI: pinGuardQ[15:8] <= regReq.wdata;
        default:           ;
      endcase
    end
  end

  // The override is registered right here, so latency is a fixed one cycle after sync.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      general_purpose_pin <= '0;
    else if (clkEn)
      general_purpose_pin <= pinOutQ[PIN_COUNT-1:0] & ~(pinGuardQ[PIN_COUNT-1:0] & {PIN_COUNT{errLevel}}); // R4
  end

  // Sticky over-current flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ocFlagAQ <= 1'b0;
      ocFlagBQ <= 1'b0;
    end
    else if (clkEn)
    begin
      if (ocaRise)
        ocFlagAQ <= 1'b1; // R5
      else if (wrEn && isAddr(regReq.addr, ADDR_OC_STATUS) && regReq.wdata[0])
        ocFlagAQ <= 1'b0;
      if (ocbRise)
        ocFlagBQ <= 1'b1; // R5
      else if (wrEn && isAddr(regReq.addr, ADDR_OC_STATUS) && regReq.wdata[1])
        ocFlagBQ <= 1'b0;
    end
  end

  // Read path, registered one cycle after the request and at the port one cycle later; zero while powered down.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      regRdataQ  <= READ_ZERO;
      regRvalidQ <= 1'b0;
    end
    else if (clkEn)
    begin
      regRvalidQ <= rdEn;
      if (!rdEn || pdnLevel)
        regRdataQ <= READ_ZERO; // R17
      else
      begin
        case (regReq.addr)
          ADDR_DEVICE_IDENTITY:     regRdataQ <= SILICON_REV[7:0]; // R7
          ADDR_DEVICE_IDENTITY + 8'h01: regRdataQ <= SILICON_REV[15:8];
          ADDR_DEVICE_IDENTITY + 8'h02: regRdataQ <= DEVICE_CODE[7:0];
          ADDR_DEVICE_IDENTITY + 8'h03: regRdataQ <= DEVICE_CODE[15:8];
          ADDR_VENDOR_CODE:         regRdataQ <= vendorQ[7:0];
          ADDR_VENDOR_CODE + 8'h01:     regRdataQ <= vendorQ[15:8];
          ADDR_PRODUCT_CODE:        regRdataQ <= productQ[7:0];
          ADDR_PRODUCT_CODE + 8'h01:    regRdataQ <= productQ[15:8];
          ADDR_PD_REVISION:         regRdataQ <= pdRevQ[7:0];
          ADDR_PD_REVISION + 8'h01:     regRdataQ <= pdRevQ[15:8];
          ADDR_CONNECTOR_REV:       regRdataQ <= connRevQ[7:0];
          ADDR_CONNECTOR_REV + 8'h01:   regRdataQ <= connRevQ[15:8];
          ADDR_WAKE_PROBE:          regRdataQ <= WAKE_PROBE_VALUE; // R13
          ADDR_TARGET_ADDRESS:      regRdataQ <= {1'b0, targetQ}; // R14
          ADDR_TIMER_LO:            regRdataQ <= timerCountQ[7:0];
          ADDR_TIMER_HI:            regRdataQ <= timerCountQ[15:8];
          ADDR_TIMER_CTRL:          regRdataQ <= {6'h00, timerIrqQ, timerRunQ};
          ADDR_PIN_OUT_LO:          regRdataQ <= pinOutQ[7:0];
          ADDR_PIN_OUT_HI:          regRdataQ <= pinOutQ[15:8];
          ADDR_PIN_GUARD_LO:        regRdataQ <= pinGuardQ[7:0];
          ADDR_PIN_GUARD_HI:        regRdataQ <= pinGuardQ[15:8];
          ADDR_OC_STATUS:           regRdataQ <= {6'h00, ocFlagBQ, ocFlagAQ};
          default:                  regRdataQ <= READ_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      regRdata      <= READ_ZERO;
      regRvalid     <= 1'b0;
      timerIrq      <= 1'b0;
      targetAddress <= 7'h00;
    end
    else if (clkEn)
    begin
      regRdata      <= regRdataQ;
      regRvalid     <= regRvalidQ;
      timerIrq      <= timerIrqQ;
      targetAddress <= targetQ;
    end
  end

  sequence underflow_s;
    clkEn && timerRunQ && kaTick && timerCountQ == 16'h0000;
  endsequence

  timer_halt_a: assert property (@(posedge ref_clk) disable iff (srst) // R2
    underflow_s |=> !timerRunQ && timerIrqQ && timerCountQ == 16'hFFFF)
    else $error("Timer did not halt with interrupt on underflow.");

  timer_step_a: assert property (@(posedge ref_clk) disable iff (srst) // R1
    clkEn && timerRunQ && kaTick && timerCountQ != 16'h0000 && !wrEn
    |=> timerCountQ == $past(timerCountQ) - 16'h0001)
    else $error("Timer did not step down on keep-alive tick.");

  pin_guard_a: assert property (@(posedge ref_clk) disable iff (srst) // R4
    clkEn && errLevel && pinGuardQ[0] |=> !general_purpose_pin[0])
    else $error("Guarded pin not forced low on error.");

  oc_sticky_a: assert property (@(posedge ref_clk) disable iff (srst) // R5
    clkEn && ocaRise |=> ocFlagAQ)
    else $error("Over-current event A not captured.");

  probe_read_a: assert property (@(posedge ref_clk) disable iff (srst) // R13
    rdEn && regReq.addr == ADDR_WAKE_PROBE && !pdnLevel |=> regRdataQ == WAKE_PROBE_VALUE)
    else $error("Wake probe did not read 02h.");

  pdn_zero_a: assert property (@(posedge ref_clk) disable iff (srst) // R17
    clkEn && pdnLevel |=> regRdataQ == READ_ZERO)
    else $error("Read data not zero while powered down.");

  pd_default_a: assert property (@(posedge ref_clk) disable iff (srst) // R11
    clkEn && resetSeenQ && !otp.pdRevValid |=> pdRevQ == RESET_PD_REVISION)
    else $error("Delivery revision default not 3010h.");

  conn_default_a: assert property (@(posedge ref_clk) disable iff (srst) // R12
    clkEn && resetSeenQ && !otp.connRevValid |=> connRevQ == RESET_CONNECTOR_REV)
    else $error("Connector revision default not 12h.");

  addr_load_a: assert property (@(posedge ref_clk) disable iff (srst) // R15
    clkEn && resetSeenQ && otp.addrOvrEn |=> targetQ == $past(otp.ovrAddr))
    else $error("Override address not loaded.");

  ro_write_a: assert property (@(posedge ref_clk) disable iff (srst) // R18
    wrEn && regReq.addr == ADDR_WAKE_PROBE |=> $stable(vendorQ) && $stable(targetQ))
    else $error("Read-only write changed state.");

endmodule : system_control_registers

// File: verif/host_model.sv
// Host processor model that drives the byte register request port.
`timescale 1ns/100ps
module host_model
  import sysctl_pkg::*;
(
  input  wire logic       ref_clk,
  output reg_req_t        regReq,
  input  wire logic [7:0] regRdata,
  input  wire logic       regRvalid
);
  initial regReq = '0;

  // A write stays up so the next request can follow at once; rd or idle drops it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a inside {[8'h0B:8'h0D]})
      return;
    @(posedge ref_clk);
    regReq <= '{1'b1, 1'b1, a, d};
  endtask : wr

  // Released fields flip so a design that samples them late sees garbage.
  task automatic idle;
    @(posedge ref_clk);
    regReq <= '{1'b0, ~regReq.write, ~regReq.addr, ~regReq.wdata};
  endtask : idle

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge ref_clk);
    regReq <= '{1'b1, 1'b0, a, 8'h5A};
    idle();
    for (int i = 0; i < 8 && !ok; i++)
    begin
      @(posedge ref_clk);
      if (regRvalid === 1'b1)
      begin
        d = regRdata;
        ok = 1'b1;
      end
    end
  endtask : rd

  // After a wake the probe is polled until the device reports itself operational.
  task automatic poll_wake(output bit ok);
    logic [7:0] d;
    bit         r;
    ok = 1'b0;
    for (int i = 0; i < 16 && !ok; i++)
    begin
      rd(ADDR_WAKE_PROBE, d, r);
      ok = r && (d === WAKE_PROBE_VALUE);
    end
  endtask : poll_wake
endmodule : host_model

// File: verif/tb_top.sv
// Self-checking bench for the system control register bank.
`timescale 1ns/100ps
module tb_top;
  import sysctl_pkg::*;
  localparam logic [15:0] DEV = 16'h2C41; // Arbitrary value.
  localparam logic [15:0] REV = 16'h0003; // Arbitrary value.
  localparam logic [15:0] VEN = 16'h7E19; // Arbitrary value.
  localparam logic [15:0] PRD = 16'h3B62; // Arbitrary value.
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        clkEn = 1'b1;
  logic        keepAliveClk = 1'b0;
  logic        poweredDown = 1'b0;
  logic        errorCondition = 1'b0;
  logic [1:0]  oc = 2'b00;
  logic [6:0]  cfgStrapAddr = 7'h2D;
  otp_fields_t otp = '0;
  reg_req_t    regReq;
  logic [7:0]  regRdata;
  logic        regRvalid;
  logic [9:0]  pins;
  logic        timerIrq;
  logic [6:0]  targetAddress;
  int          err_total = 0;
  int          n_tests = 0;
  logic [7:0]  d;
  logic [15:0] pv;
  logic [15:0] gv;
  bit          ok;

  always #5 ref_clk = ~ref_clk;

  system_control_registers #(.PIN_COUNT(10), .DEVICE_CODE(DEV), .SILICON_REV(REV), .VENDOR_CODE(VEN),
    .PRODUCT_CODE(PRD)) system_control_registers_inst (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn),
    .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid), .otp(otp), .cfgStrapAddr(cfgStrapAddr),
    .poweredDown(poweredDown), .keepAliveClk(keepAliveClk), .overcurrent_sense_input_a(oc[0]),
    .overcurrent_sense_input_b(oc[1]), .errorCondition(errorCondition), .general_purpose_pin(pins),
    .timerIrq(timerIrq), .targetAddress(targetAddress));

  host_model host_model_inst (.ref_clk(ref_clk), .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid));

  function automatic logic [7:0] id_byte(input int k);
    logic [31:0] w;
    w = {DEV, REV} >> (8 * k);
    return w[7:0];
  endfunction : id_byte

  function automatic logic [15:0] pin_exp(input logic [15:0] v, input logic [15:0] g, input logic e);
    return v & ~(g & {16{e}}) & 16'h03FF;
  endfunction : pin_exp

  task automatic complete_run;
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host_model_inst.rd(a, d, ok);
    if (!ok)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: no read answer from %h", $time, a);
      complete_run();
    end
    else
      chk({8'h00, d}, {8'h00, exp});
  endtask : rdchk

  task automatic rd16(input logic [7:0] a, input logic [15:0] exp);
    rdchk(a, exp[7:0]);
    rdchk(a + 8'h01, exp[15:8]);
  endtask : rd16

  task automatic do_reset;
    srst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask : do_reset

  task automatic tick;
    @(posedge ref_clk);
    keepAliveClk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    keepAliveClk <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : tick

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    err_total++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    complete_run();
  end

  initial
  begin
    void'($urandom(82957));
    do_reset();
    for (int k = 0; k < 4; k++)
      rdchk(8'(k), id_byte(k));
    rd16(ADDR_VENDOR_CODE, VEN);
    rd16(ADDR_PRODUCT_CODE, PRD);
    rd16(ADDR_PD_REVISION, RESET_PD_REVISION);
    rd16(ADDR_CONNECTOR_REV, RESET_CONNECTOR_REV);
    rdchk(ADDR_TARGET_ADDRESS, {1'b0, cfgStrapAddr});
    for (int i = 0; i < 6; i++)
    begin
      pv = 16'($urandom);
      host_model_inst.wr(ADDR_VENDOR_CODE, pv[7:0]);
      host_model_inst.wr(ADDR_VENDOR_CODE + 8'h01, pv[15:8]);
      host_model_inst.wr(ADDR_PRODUCT_CODE + 8'h01, pv[7:0]);
      rd16(ADDR_VENDOR_CODE, pv);
      rdchk(ADDR_PRODUCT_CODE + 8'h01, pv[7:0]);
    end
    for (int k = 0; k < 4; k++)
      host_model_inst.wr(8'(k), ~id_byte(k));
    host_model_inst.wr(ADDR_WAKE_PROBE, 8'hFD);
    host_model_inst.wr(ADDR_TARGET_ADDRESS, 8'hFF);
    for (int k = 0; k < 4; k++)
      rdchk(8'(k), id_byte(k));
    rdchk(ADDR_WAKE_PROBE, WAKE_PROBE_VALUE);
    rdchk(ADDR_TARGET_ADDRESS, 8'h7F);
    chk(16'(targetAddress), 16'h007F);
    poweredDown <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdchk(ADDR_WAKE_PROBE, 8'h00);
    poweredDown <= 1'b0;
    host_model_inst.poll_wake(ok);
    chk(16'(ok), 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      pv = 16'($urandom) & 16'h03FF;
      gv = 16'($urandom) & 16'h03FF;
      host_model_inst.wr(ADDR_PIN_OUT_LO, pv[7:0]);
      host_model_inst.wr(ADDR_PIN_OUT_HI, pv[15:8]);
      host_model_inst.wr(ADDR_PIN_GUARD_LO, gv[7:0]);
      host_model_inst.wr(ADDR_PIN_GUARD_HI, gv[15:8]);
      host_model_inst.idle();
      for (int e = 0; e < 2; e++)
      begin
        errorCondition <= e[0];
        repeat (5) @(posedge ref_clk);
        chk(16'(pins), pin_exp(pv, gv, e[0]));
      end
    end
    // With the enable low the pins must keep the forced state although the error has gone.
    clkEn <= 1'b0;
    errorCondition <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk(16'(pins), pin_exp(pv, gv, 1'b1));
    clkEn <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(16'(pins), pin_exp(pv, gv, 1'b0));
    for (int b = 0; b < 2; b++)
    begin
      oc[b] <= 1'b1;
      repeat (3) @(posedge ref_clk);
      oc[b] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rdchk(ADDR_OC_STATUS, 8'(2 * b + 1));
    end
    host_model_inst.wr(ADDR_OC_STATUS, 8'h03);
    rdchk(ADDR_OC_STATUS, 8'h00);
    host_model_inst.wr(ADDR_TIMER_LO, 8'h03);
    host_model_inst.wr(ADDR_TIMER_HI, 8'h00);
    host_model_inst.wr(ADDR_TIMER_CTRL, 8'h01);
    host_model_inst.idle();
    repeat (3) tick();
    chk(16'(timerIrq), 16'h0000);
    rdchk(ADDR_TIMER_CTRL, 8'h01);
    rdchk(ADDR_TIMER_LO, 8'h00);
    tick();
    chk(16'(timerIrq), 16'h0001);
    repeat (2) tick();
    rdchk(ADDR_TIMER_CTRL, 8'h02);
    rdchk(ADDR_TIMER_HI, 8'hFF);
    host_model_inst.wr(ADDR_TIMER_CTRL, 8'h02);
    rdchk(ADDR_TIMER_CTRL, 8'h00);
    // Second pass shows the override winning over a freshly sampled strap.
    for (int j = 0; j < 2; j++)
    begin
      pv = 16'($urandom);
      gv = 16'($urandom);
      cfgStrapAddr <= gv[14:8];
      otp <= '{j[0], pv[6:0], 1'b1, pv, 1'b1, gv};
      do_reset();
      rd16(ADDR_PD_REVISION, pv);
      rd16(ADDR_CONNECTOR_REV, gv);
      chk(16'(targetAddress), 16'(j ? pv[6:0] : gv[14:8]));
    end
    complete_run();
  end
endmodule : tb_top
